// file: design/tpg_frame_pkg.sv
package tpg_frame_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [7:0] reg_addr_t;

  // register offsets within the pattern page
  localparam reg_addr_t OFS_CTL        = 8'h01;
  localparam reg_addr_t OFS_LINE_HI    = 8'h04;
  localparam reg_addr_t OFS_LINE_LO    = 8'h05;
  localparam reg_addr_t OFS_BAR_HI     = 8'h06;
  localparam reg_addr_t OFS_BAR_LO     = 8'h07;
  localparam reg_addr_t OFS_ACT_HI     = 8'h08;
  localparam reg_addr_t OFS_ACT_LO     = 8'h09;
  localparam reg_addr_t OFS_TOT_HI     = 8'h0A;
  localparam reg_addr_t OFS_TOT_LO     = 8'h0B;
  localparam reg_addr_t OFS_PERIOD_HI  = 8'h0C;
  localparam reg_addr_t OFS_PERIOD_LO  = 8'h0D;
  localparam reg_addr_t OFS_BACK_PORCH = 8'h0E;
  localparam reg_addr_t OFS_FRONT_PORCH = 8'h0F;

  // storage depth and index width of the byte register file
  localparam int unsigned REG_DEPTH = 16;
  localparam int unsigned REG_IDX_W = 4;

  // reset values
  localparam reg_byte_t RST_CTL         = 8'h00;
  localparam reg_byte_t RST_LINE_HI     = 8'h07;
  localparam reg_byte_t RST_LINE_LO     = 8'h80;
  localparam reg_byte_t RST_BAR_HI      = 8'h00;
  localparam reg_byte_t RST_BAR_LO      = 8'hF0;
  localparam reg_byte_t RST_ACT_HI      = 8'h01;
  localparam reg_byte_t RST_ACT_LO      = 8'hE0;
  localparam reg_byte_t RST_TOT_HI      = 8'h02;
  localparam reg_byte_t RST_TOT_LO      = 8'h0D;
  localparam reg_byte_t RST_PERIOD_HI   = 8'h0C;
  localparam reg_byte_t RST_PERIOD_LO   = 8'h67;
  localparam reg_byte_t RST_BACK_PORCH  = 8'h21;
  localparam reg_byte_t RST_FRONT_PORCH = 8'h0A;
  localparam reg_byte_t RST_NONE        = 8'h00;

  // control byte: only the enable bit is writable, the rest reads zero
  localparam int unsigned CTL_ON_BIT  = 0;
  localparam reg_byte_t   CTL_WR_MASK = 8'h01;

  // reference cycles per line-period unit
  localparam int unsigned UNIT_CYCLES = 40;

  // vertical phase of the current line
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_BACK  = 3'b001,
    PH_ACT   = 3'b010,
    PH_FRONT = 3'b011,
    PH_TAIL  = 3'b100
  } phase_t;

endpackage

// file: design/line_period_timer.sv
module line_period_timer #(
  parameter int unsigned UNIT_CYCLES_P = 40,
  parameter int unsigned PERIOD_W      = 16
) (
  input  wire logic                clock_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  input  wire logic                run_i,
  input  wire logic [PERIOD_W-1:0] period_i,
  output logic                     tick_o
);

  localparam int unsigned UNIT_W = $clog2(UNIT_CYCLES_P + 1);
  localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(UNIT_CYCLES_P - 1);

  initial begin
    if (UNIT_CYCLES_P < 1 || PERIOD_W < 1) begin
      $error("line_period_timer: unit and period width must be at least one");
    end
  end

  logic [UNIT_W-1:0]   unit_q;
  logic [PERIOD_W-1:0] units_q;
  logic [PERIOD_W-1:0] last_unit;

  // zero period behaves as one unit
  assign last_unit = (period_i == '0) ? '0 : PERIOD_W'(period_i - 1'b1);

  // unit prescaler and unit counter, one tick per line
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      unit_q  <= '0;
      units_q <= '0;
      tick_o  <= 1'b0;
    end else if (ce_i) begin
      tick_o <= 1'b0;
      if (!run_i) begin
        unit_q  <= '0;
        units_q <= '0;
      end else if (unit_q == UNIT_LAST) begin
        unit_q <= '0;
        if (units_q >= last_unit) begin
          units_q <= '0;
          tick_o  <= 1'b1;
        end else begin
          units_q <= PERIOD_W'(units_q + 1'b1);
        end
      end else begin
        unit_q <= UNIT_W'(unit_q + 1'b1);
      end
    end
  end

endmodule

// file: design/test_pattern_frame_timing.sv
module test_pattern_frame_timing #(
  parameter int unsigned BAR_IDX_W = 3
) (
  input  wire logic                      clock_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      ce_i,
  input  wire tpg_frame_pkg::reg_addr_t  reg_addr_i,
  input  wire tpg_frame_pkg::reg_byte_t  reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output tpg_frame_pkg::reg_byte_t       reg_rdata_o,
  input  wire logic [BAR_IDX_W-1:0]      final_bar_i,
  input  wire logic                      byte_ready_i,
  output logic                           byte_valid_o,
  output logic                           byte_last_o,
  output logic [BAR_IDX_W-1:0]           bar_index_o,
  output logic [15:0]                    byte_offset_o,
  output logic                           frame_start_o,
  output logic                           frame_end_o,
  output logic                           line_start_o,
  output tpg_frame_pkg::phase_t          phase_o
);
  import tpg_frame_pkg::*;

  initial begin
    if (BAR_IDX_W < 1 || BAR_IDX_W > 8) begin
      $error("test_pattern_frame_timing: BAR_IDX_W must be 1 to 8");
    end
  end

  // reset value by register index
  function automatic reg_byte_t reset_value(input logic [REG_IDX_W-1:0] idx);
    case (8'(idx))
      OFS_CTL:         reset_value = RST_CTL;
      OFS_LINE_HI:     reset_value = RST_LINE_HI;
      OFS_LINE_LO:     reset_value = RST_LINE_LO;
      OFS_BAR_HI:      reset_value = RST_BAR_HI;
      OFS_BAR_LO:      reset_value = RST_BAR_LO;
      OFS_ACT_HI:      reset_value = RST_ACT_HI;
      OFS_ACT_LO:      reset_value = RST_ACT_LO;
      OFS_TOT_HI:      reset_value = RST_TOT_HI;
      OFS_TOT_LO:      reset_value = RST_TOT_LO;
      OFS_PERIOD_HI:   reset_value = RST_PERIOD_HI;
      OFS_PERIOD_LO:   reset_value = RST_PERIOD_LO;
      OFS_BACK_PORCH:  reset_value = RST_BACK_PORCH;
      OFS_FRONT_PORCH: reset_value = RST_FRONT_PORCH;
      default:         reset_value = RST_NONE;
    endcase
  endfunction

  // offsets that hold storage in this block
  function automatic logic is_mapped(input reg_addr_t addr);
    is_mapped = (addr == OFS_CTL) || (addr >= OFS_LINE_HI && addr <= OFS_FRONT_PORCH);
  endfunction

  reg_byte_t regs_q [REG_DEPTH];

  // byte register file with documented offsets
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        regs_q[i] <= reset_value(REG_IDX_W'(i));
      end
    end else if (ce_i && reg_wr_i && is_mapped(reg_addr_i)) begin
      if (reg_addr_i == OFS_CTL) begin
        regs_q[REG_IDX_W'(reg_addr_i)] <= reg_wdata_i & CTL_WR_MASK;
      end else begin
        regs_q[REG_IDX_W'(reg_addr_i)] <= reg_wdata_i;
      end
    end
  end

  // registered read port, unmapped offsets read zero
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else if (ce_i && reg_rd_i) begin
      reg_rdata_o <= is_mapped(reg_addr_i) ? regs_q[REG_IDX_W'(reg_addr_i)] : '0;
    end
  end

  // assembled settings
  logic [15:0] line_bytes, bar_bytes, act_lines, tot_lines, period_units;
  logic [7:0]  back_lines, front_lines;
  logic        gen_on;
  assign line_bytes   = {regs_q[REG_IDX_W'(OFS_LINE_HI)], regs_q[REG_IDX_W'(OFS_LINE_LO)]};
  assign bar_bytes    = {regs_q[REG_IDX_W'(OFS_BAR_HI)], regs_q[REG_IDX_W'(OFS_BAR_LO)]};
  assign act_lines    = {regs_q[REG_IDX_W'(OFS_ACT_HI)], regs_q[REG_IDX_W'(OFS_ACT_LO)]};
  assign tot_lines    = {regs_q[REG_IDX_W'(OFS_TOT_HI)], regs_q[REG_IDX_W'(OFS_TOT_LO)]};
  assign period_units = {regs_q[REG_IDX_W'(OFS_PERIOD_HI)],
                         regs_q[REG_IDX_W'(OFS_PERIOD_LO)]};
  assign back_lines   = regs_q[REG_IDX_W'(OFS_BACK_PORCH)];
  assign front_lines  = regs_q[REG_IDX_W'(OFS_FRONT_PORCH)];
  assign gen_on       = regs_q[REG_IDX_W'(OFS_CTL)][CTL_ON_BIT];

  // phase boundaries as line indices within the frame
  logic [17:0] act_first, front_first, tail_first;
  assign act_first   = 18'(back_lines);
  assign front_first = 18'(act_first + 18'(act_lines));
  assign tail_first  = 18'(front_first + 18'(front_lines));

  // phase of a given line index
  function automatic phase_t phase_of(input logic [17:0] idx, input logic [17:0] a_first,
                                      input logic [17:0] f_first, input logic [17:0] t_first);
    if (idx < a_first) begin
      phase_of = PH_BACK;
    end else if (idx < f_first) begin
      phase_of = PH_ACT;
    end else if (idx < t_first) begin
      phase_of = PH_FRONT;
    end else begin
      phase_of = PH_TAIL;
    end
  endfunction

  logic        run_q;
  logic        end_owed_q;
  logic [17:0] line_idx_q;
  logic [17:0] next_idx;
  phase_t      next_phase;
  phase_t      first_phase;
  logic        line_tick;
  logic        frame_done;

  assign next_idx    = 18'(line_idx_q + 18'd1);
  assign next_phase  = phase_of(next_idx, act_first, front_first, tail_first);
  assign first_phase = phase_of('0, act_first, front_first, tail_first);
  assign frame_done  = !end_owed_q && (next_idx >= 18'(tot_lines));

  line_period_timer #(
    .UNIT_CYCLES_P (UNIT_CYCLES),
    .PERIOD_W      (16)
  ) u_line_timer (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .ce_i     (ce_i),
    .run_i    (gen_on), // starts with the frame so the first line is a full period
    .period_i (period_units),
    .tick_o   (line_tick)
  );

  // vertical sequencer, one step per line tick
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      run_q         <= 1'b0;
      end_owed_q    <= 1'b0;
      line_idx_q    <= '0;
      phase_o       <= PH_IDLE;
      frame_start_o <= 1'b0;
      frame_end_o   <= 1'b0;
      line_start_o  <= 1'b0;
    end else if (ce_i) begin
      frame_start_o <= 1'b0;
      frame_end_o   <= 1'b0;
      line_start_o  <= 1'b0;
      if (!gen_on) begin
        frame_end_o <= run_q && end_owed_q;
        run_q       <= 1'b0;
        end_owed_q  <= 1'b0;
        line_idx_q  <= '0;
        phase_o     <= PH_IDLE;
      end else if (!run_q || (line_tick && frame_done)) begin
        run_q         <= 1'b1;
        end_owed_q    <= 1'b1;
        line_idx_q    <= '0;
        phase_o       <= first_phase;
        frame_start_o <= 1'b1;
        line_start_o  <= (first_phase == PH_ACT);
      end else if (line_tick) begin
        line_idx_q   <= next_idx;
        phase_o      <= next_phase;
        line_start_o <= (next_phase == PH_ACT);
        if (next_phase == PH_TAIL && end_owed_q) begin
          frame_end_o <= 1'b1;
          end_owed_q  <= 1'b0;
        end
      end
    end
  end

  logic [15:0] bar_pos_q;
  logic [15:0] bar_end;
  assign bar_end = (bar_bytes == '0) ? '0 : 16'(bar_bytes - 16'd1);

  // byte stream of one active line with bar tracking
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      byte_valid_o  <= 1'b0;
      byte_last_o   <= 1'b0;
      bar_index_o   <= '0;
      byte_offset_o <= '0;
      bar_pos_q     <= '0;
    end else if (ce_i) begin
      if (!gen_on) begin
        byte_valid_o <= 1'b0;
        byte_last_o  <= 1'b0;
      end else if (line_start_o) begin
        byte_valid_o  <= (line_bytes != '0);
        byte_last_o   <= (line_bytes == 16'd1);
        byte_offset_o <= '0;
        bar_index_o   <= '0;
        bar_pos_q     <= '0;
      end else if (byte_valid_o && byte_ready_i) begin
        if (byte_last_o) begin
          byte_valid_o <= 1'b0;
          byte_last_o  <= 1'b0;
        end else begin
          byte_offset_o <= 16'(byte_offset_o + 16'd1);
          byte_last_o   <= (17'(byte_offset_o) + 17'd2 == 17'(line_bytes));
          if (bar_index_o != final_bar_i && bar_pos_q >= bar_end) begin
            bar_index_o <= BAR_IDX_W'(bar_index_o + 1'b1);
            bar_pos_q   <= '0;
          end else begin
            bar_pos_q <= 16'(bar_pos_q + 16'd1);
          end
        end
      end
    end
  end

endmodule

// file: tb/tpg_frame_timing_asserts.sv
module tpg_frame_asserts
  import tpg_frame_pkg::*;
#(
  parameter int unsigned BAR_IDX_W = 3
) (
  input wire logic                 clock_i,
  input wire logic                 rst_n_i,
  input wire logic                 ce_i,
  input wire reg_addr_t            reg_addr_i,
  input wire logic                 reg_rd_i,
  input wire reg_byte_t            reg_rdata_o,
  input wire logic                 byte_ready_i,
  input wire logic                 byte_valid_o,
  input wire logic                 byte_last_o,
  input wire logic [BAR_IDX_W-1:0] bar_index_o,
  input wire logic [15:0]          byte_offset_o,
  input wire logic                 frame_start_o,
  input wire logic                 frame_end_o,
  input wire logic                 line_start_o,
  input wire phase_t               phase_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] gap_q;
  logic        armed_q;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // cycles since the last active line began, forgotten while idle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || phase_o == PH_IDLE) begin
      gap_q   <= 16'h0000;
      armed_q <= 1'b0;
    end else begin
      gap_q   <= line_start_o ? 16'h0001 : gap_q + 16'h0001;
      armed_q <= armed_q | line_start_o;
    end
  end

  a_first_byte: assert property (line_start_o |=> phase_o == PH_IDLE ||
    byte_valid_o && byte_offset_o == 16'h0000 && bar_index_o == '0)
    else $error("line did not open at byte 0 of bar 0");
  a_offset_step: assert property (byte_valid_o && byte_ready_i && !byte_last_o |=>
    line_start_o || phase_o == PH_IDLE || byte_offset_o == $past(byte_offset_o) + 16'h0001)
    else $error("accepted byte did not advance the offset");
  a_last_closes: assert property (byte_valid_o && byte_ready_i && byte_last_o |=>
    !byte_valid_o || line_start_o) else $error("stream went on after last byte");
  a_stall_holds: assert property (byte_valid_o && !byte_ready_i |=>
    byte_valid_o && $stable(byte_offset_o) || line_start_o || phase_o == PH_IDLE)
    else $error("byte changed while stalled");
  a_line_active: assert property (line_start_o |-> phase_o == PH_ACT)
    else $error("line started outside active phase");
  a_idle_silent: assert property (phase_o == PH_IDLE |->
    !byte_valid_o && !line_start_o && !frame_start_o) else $error("output while idle");
  a_line_spacing: assert property (line_start_o && armed_q |->
    32'(gap_q) % UNIT_CYCLES == 0) else $error("line spacing not whole units");
  a_end_quiet: assert property (frame_end_o |-> !byte_valid_o ##1 !frame_end_o)
    else $error("frame end not a lone quiet pulse");
  a_ctl_reserved: assert property (ce_i && reg_rd_i && reg_addr_i == OFS_CTL |=>
    reg_rdata_o[7:1] == 7'h00) else $error("reserved control bits read nonzero");

  c_frame: cover property (frame_start_o);
  c_stall: cover property (byte_valid_o && !byte_ready_i);
  c_last: cover property (byte_last_o && byte_ready_i);
endmodule

bind test_pattern_frame_timing tpg_frame_asserts #(.BAR_IDX_W(BAR_IDX_W)) u_tpg_frame_asserts (
  .clock_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .byte_ready_i,
  .byte_valid_o, .byte_last_o, .bar_index_o, .byte_offset_o, .frame_start_o,
  .frame_end_o, .line_start_o, .phase_o);

// file: tb/byte_sink_model.sv
module byte_sink_model (
  input  wire logic clock_i,
  input  wire logic stall_i,
  output logic      byte_ready_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lfsr_q = 4'h1;

  // packet builder: takes every byte, or stalls on a pseudo-random pattern
  always @(posedge clock_i) begin
    lfsr_q       <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
    byte_ready_o <= !stall_i || lfsr_q[0];
  end
endmodule

// file: tb/test_pattern_frame_timing_test.sv
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end

module test_pattern_frame_timing_test;
  timeunit 1ns;
  timeprecision 1ns;
  import tpg_frame_pkg::*;
  logic        clock_i = 1'b0, rst_n_i = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        rd_seen = 1'b0, stall = 1'b0, ce = 1'b1;
  logic        byte_ready, byte_valid, byte_last, frame_start, frame_end, line_start;
  logic [2:0]  bar_index;
  logic [2:0]  final_bar = 3'h0;
  logic [15:0] byte_offset;
  logic [31:0] seed = 32'h8b53_cc8a;
  reg_addr_t   addr = 8'h00;
  reg_byte_t   wdata = 8'h00;
  reg_byte_t   rdata, rexp;
  logic [19:0] bexp;
  phase_t      phase;
  int          fail_count, comparisons, cyc, len, bwe, fin, act, vals[12];
  int          fs_q[$], fe_q[$], ls_q[$];
  reg_byte_t   rq[$];
  logic [19:0] bq[$];
  logic [15:0] rst_tab[15] = '{16'h0100, 16'h0407, 16'h0580, 16'h0600, 16'h07f0, 16'h0801,
    16'h09e0, 16'h0a02, 16'h0b0d, 16'h0c0c, 16'h0d67, 16'h0e21, 16'h0f0a, 16'h0200, 16'h1000};

  always #25 clock_i = ~clock_i;

  test_pattern_frame_timing u_test_pattern_frame_timing (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .ce_i(ce), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .final_bar_i(final_bar),
    .byte_ready_i(byte_ready), .byte_valid_o(byte_valid), .byte_last_o(byte_last),
    .bar_index_o(bar_index), .byte_offset_o(byte_offset), .frame_start_o(frame_start),
    .frame_end_o(frame_end), .line_start_o(line_start), .phase_o(phase));
  byte_sink_model u_byte_sink_model (.clock_i(clock_i), .stall_i(stall),
    .byte_ready_o(byte_ready));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    @(negedge clock_i);
    addr = a;
    wdata = d;
    reg_wr = 1'b1;
    @(negedge clock_i);
    reg_wr = 1'b0;
  endtask

  // read strobe for one cycle, expected byte noted for the monitor
  task automatic rd(input reg_addr_t a, input reg_byte_t e);
    @(negedge clock_i);
    addr = a;
    reg_rd = 1'b1;
    rq.push_back(e);
    @(negedge clock_i);
    reg_rd = 1'b0;
  endtask

  task automatic wait_for(ref int q[$], input int n);
    repeat (2000) if (q.size() < n) @(negedge clock_i);
    if (q.size() < n) begin
      fail_count++;
      wrap_up();
    end
  endtask

  always @(posedge clock_i) rd_seen <= reg_rd;

  // note pulse times, compare read data and each accepted byte with the oldest note
  always @(negedge clock_i) begin
    cyc++;
    if (frame_start) fs_q.push_back(cyc);
    if (frame_end) fe_q.push_back(cyc);
    if (line_start) ls_q.push_back(cyc);
    if (rd_seen) begin
      rexp = rq.pop_front();
      `CHK("rdata", rexp, rdata)
    end
    if (byte_valid && byte_ready) begin
      bexp = bq.pop_front();
      `CHK("byte", bexp, {byte_last, bar_index, byte_offset})
    end
  end

  initial begin
    repeat (12) @(negedge clock_i);
    rst_n_i = 1'b1;
    foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
    for (int a = 4; a < 16; a++) begin
      wdata = 8'(rnd());
      rd(8'(a), rst_tab[a - 3][7:0]);
      wr(8'(a), wdata);
      rd(8'(a), wdata);
    end
    wr(OFS_CTL, 8'hfe);
    rd(OFS_CTL, 8'h00);
    // a write while the clock enable is low must not land
    ce = 1'b0;
    wr(OFS_CTL, 8'h01);
    ce = 1'b1;
    rd(OFS_CTL, 8'h00);
    for (int k = 0; k < 2; k++) begin
      len = k ? 3 : 5 + rnd() % 6;
      bwe = k ? 1 : 2;
      fin = k ? 1 : 2;
      act = k ? 2 : 3;
      stall = !k;
      final_bar = 3'(fin);
      vals = '{0, len, 0, k ? 0 : 2, 0, act, 0, k ? 4 : 8, 0, 1, k ? 0 : 2, k ? 0 : 1};
      foreach (vals[i]) wr(8'(i + 4), 8'(vals[i]));
      fs_q = {};
      fe_q = {};
      ls_q = {};
      for (int n = 0; n < 2 * act * len; n++)
        bq.push_back({n % len == len - 1, 3'(n % len / bwe > fin ? fin : n % len / bwe),
          16'(n % len)});
      wr(OFS_CTL, 8'h01);
      wait_for(fe_q, 2);
      if (!k) wait_for(fs_q, 3);
      wr(OFS_CTL, 8'h00);
      repeat (3) @(negedge clock_i);
      `CHK("phase", PH_IDLE, phase)
      `CHK("ends", 3 - k, fe_q.size())
      `CHK("lines", 2 * act, ls_q.size())
      `CHK("porch_b", vals[10] * 40, ls_q[0] - fs_q[0])
      `CHK("porch_f", (vals[11] + 1) * 40, fe_q[0] - ls_q[act - 1])
      `CHK("period", 40, ls_q[1] - ls_q[0])
      `CHK("frame", vals[7] * 40, fs_q[1] - fs_q[0])
      `CHK("bytes", 0, bq.size())
    end
    wrap_up();
  end
endmodule
